// >>> design/esp_defs.vh
// Constants for the ESTOP motor power supervisor: offsets, fields, resets, timing.
// Assumes a 200 MHz single clock and a 32-bit APB register port.
`ifndef ESP_DEFS_VH
`define ESP_DEFS_VH

// Clock and timing
`define ESP_CLK_MHZ 200
`define ESP_DB_TIME_US 1000
`define ESP_DB_CYCLES (`ESP_DB_TIME_US * `ESP_CLK_MHZ)
`define ESP_BLINK_MS 250
`define ESP_BLINK_CYCLES (`ESP_BLINK_MS * 1000 * `ESP_CLK_MHZ)

// Register byte offsets
`define ESP_ADDR_W 8
`define ESP_OFF_CTRL 8'h00
`define ESP_OFF_STATUS 8'h04
`define ESP_OFF_INT_STAT 8'h08
`define ESP_OFF_INT_MASK 8'h0C
`define ESP_OFF_BLINK_DIV 8'h10

// CTRL fields
`define ESP_CTRL_SOFT_ESTOP 0
`define ESP_CTRL_SOFT_RESET 1
`define ESP_CTRL_RESET 2'h0

// STATUS fields
`define ESP_ST_STATE_LO 0
`define ESP_ST_STATE_HI 1
`define ESP_ST_POWER 2
`define ESP_ST_RELAY 3
`define ESP_ST_LOGIC 4
`define ESP_ST_BRAKE1 5
`define ESP_ST_BRAKE2 6
`define ESP_ST_SW_LO 8
`define ESP_ST_SW_HI 15
`define ESP_ST_IN_LO 16
`define ESP_ST_IN_HI 23

// Interrupt status / mask fields
`define ESP_INT_W 5
`define ESP_INT_TRIP 0
`define ESP_INT_RUN 1
`define ESP_INT_MOTOR_UV 2
`define ESP_INT_LOW24 3
`define ESP_INT_REGEN 4
`define ESP_INT_MASK_RESET 5'h00

// Configuration switch positions (switch n is bit n-1)
`define ESP_SW_RESET_CFG 0
`define ESP_SW_BRAKE_POL 1
`define ESP_SW_LOGIC_OUT 2
`define ESP_SW_RELAY_OUT 3
`define ESP_SW_INT_ESTOP 4
`define ESP_SW_EXT_ESTOP 5
`define ESP_SW_UV_MON 6

// Debounced contact vector positions
`define ESP_IN_N 16
`define ESP_IN_INT 8
`define ESP_IN_EXT 9
`define ESP_IN_RESET 10
`define ESP_IN_BRAKE1 11
`define ESP_IN_BRAKE2 12
`define ESP_IN_MOTOR_UV 13
`define ESP_IN_LOW24 14
`define ESP_IN_REGEN 15

// Supervisor states
`define ESP_STATE_TRIP 2'h0
`define ESP_STATE_WAIT 2'h1
`define ESP_STATE_RUN 2'h2

`endif

// >>> design/esp_supervisor.v
// ESTOP motor power supervisor: contact debounce, power state machine,
// brake polarity, relay and logic outputs, blink-coded LED, APB registers.
// Assumes all pins are synchronous to I_MCLK; contacts are high when closed.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "esp_defs.vh"

module esp_debounce #(
	parameter CNT_W = 18,
	parameter [CNT_W-1:0] CYCLES = 18'd1000
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// Raw contact and clean level
	input wire i_raw,
	output reg o_clean
);
	reg sync1_q;
	reg sync2_q;
	reg [CNT_W-1:0] cnt_q;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			cnt_q <= {CNT_W{1'b0}};
			o_clean <= 1'b0;
		end else begin
			sync1_q <= i_raw;
			sync2_q <= sync1_q;
			// Level must hold for CYCLES before it is accepted
			if (sync2_q == o_clean) begin
				cnt_q <= {CNT_W{1'b0}};
			end else if (cnt_q >= CYCLES - 1'b1) begin
				cnt_q <= {CNT_W{1'b0}};
				o_clean <= sync2_q;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule

module esp_supervisor #(
	parameter DB_W = 18,
	parameter [DB_W-1:0] DEBOUNCE_CYCLES = `ESP_DB_CYCLES,
	parameter [31:0] BLINK_RESET = `ESP_BLINK_CYCLES
) (
	// Clock and reset
	input wire I_MCLK,
	input wire I_RST_N,
	// APB slave
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [`ESP_ADDR_W-1:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output reg [31:0] O_PRDATA,
	output reg O_PREADY,
	output reg O_PSLVERR,
	// Configuration switch bank
	input wire [7:0] I_CFG_SW,
	// Contacts, high when closed
	input wire I_ESTOP_INT_CLOSED,
	input wire I_ESTOP_EXT_CLOSED,
	input wire I_RESET_CONTACT,
	// Brake requests from the drives
	input wire I_BRAKE1_REQ,
	input wire I_BRAKE2_REQ,
	// Supply monitors, high when faulted
	input wire I_MOTOR_UV,
	input wire I_LOW24_UV,
	input wire I_REGEN_LOCK,
	// Power and safety outputs
	output reg O_MOTOR_PWR_EN,
	output reg O_ESTOP_LOGIC,
	output reg O_RELAY_CLOSED,
	output reg O_BRAKE1,
	output reg O_BRAKE2,
	// Status LED
	output reg O_LED_GREEN,
	output reg O_LED_RED,
	// Interrupt
	output reg O_IRQ
);
	wire [`ESP_IN_N-1:0] raw_in;
	wire [`ESP_IN_N-1:0] clean_in;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg reset_prev_q;
	reg [1:0] ctrl_q;
	reg soft_reset_q;
	reg [`ESP_INT_W-1:0] int_stat_q;
	reg [`ESP_INT_W-1:0] int_mask_q;
	reg [31:0] blink_div_q;
	reg [31:0] blink_cnt_q;
	reg blink_tick_q;
	reg [1:0] phase_q;
	reg [2:0] uv_prev_q;
	reg [DB_W:0] boot_cnt_q;
	reg boot_done_q;
	reg led_g_d;
	reg led_r_d;
	reg [31:0] rd_d;
	reg addr_ok;

	assign raw_in = {I_REGEN_LOCK, I_LOW24_UV, I_MOTOR_UV, I_BRAKE2_REQ, I_BRAKE1_REQ,
		I_RESET_CONTACT, I_ESTOP_EXT_CLOSED, I_ESTOP_INT_CLOSED, I_CFG_SW};

	// One debouncer per contact
	genvar gi;
	generate
		for (gi = 0; gi < `ESP_IN_N; gi = gi + 1) begin : g_db
			esp_debounce #(
				.CNT_W(DB_W),
				.CYCLES(DEBOUNCE_CYCLES)
			) u_db (
				.i_clk(I_MCLK),
				.i_rst_n(I_RST_N),
				.i_raw(raw_in[gi]),
				.o_clean(clean_in[gi])
			);
		end
	endgenerate

	wire sw_reset_cfg = clean_in[`ESP_SW_RESET_CFG];
	wire sw_brake_pol = clean_in[`ESP_SW_BRAKE_POL];
	wire sw_logic_out = clean_in[`ESP_SW_LOGIC_OUT];
	wire sw_relay_out = clean_in[`ESP_SW_RELAY_OUT];
	wire sw_int_estop = clean_in[`ESP_SW_INT_ESTOP];
	wire sw_ext_estop = clean_in[`ESP_SW_EXT_ESTOP];
	wire sw_uv_mon = clean_in[`ESP_SW_UV_MON];

	// Loop health, ignoring loops that are switched out
	wire int_ok = !sw_int_estop || clean_in[`ESP_IN_INT];
	wire ext_ok = !sw_ext_estop || clean_in[`ESP_IN_EXT];
	wire loops_ok = int_ok && ext_ok && !ctrl_q[`ESP_CTRL_SOFT_ESTOP];

	// Under-voltage seen only with the monitor enabled
	wire motor_uv = sw_uv_mon && clean_in[`ESP_IN_MOTOR_UV];
	wire low24_uv = sw_uv_mon && clean_in[`ESP_IN_LOW24];
	wire uv_fault = motor_uv || low24_uv;
	wire regen_lock = clean_in[`ESP_IN_REGEN];

	// Momentary closure: rising edge of clean reset contact, or software pulse
	wire reset_pulse = (clean_in[`ESP_IN_RESET] && !reset_prev_q) || soft_reset_q;

	// Hold TRIP until every debouncer has seen its real input, not the reset zeros
	wire [DB_W:0] boot_end = {1'b0, DEBOUNCE_CYCLES} + {{(DB_W - 1){1'b0}}, 2'h2};
	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			boot_cnt_q <= {(DB_W + 1){1'b0}};
			boot_done_q <= 1'b0;
		end else if (!boot_done_q) begin
			if (boot_cnt_q == boot_end) begin
				boot_done_q <= 1'b1;
			end else begin
				boot_cnt_q <= boot_cnt_q + 1'b1;
			end
		end
	end

	// Power state machine
	always @* begin
		state_d = state_q;
		case (state_q)
			`ESP_STATE_RUN: begin
				if (!loops_ok || uv_fault) begin
					state_d = `ESP_STATE_TRIP;
				end
			end
			`ESP_STATE_TRIP: begin
				if (boot_done_q && loops_ok && !uv_fault) begin
					state_d = sw_reset_cfg ? `ESP_STATE_WAIT : `ESP_STATE_RUN;
				end
			end
			`ESP_STATE_WAIT: begin
				if (!loops_ok || uv_fault) begin
					state_d = `ESP_STATE_TRIP;
				end else if (!sw_reset_cfg || reset_pulse) begin
					state_d = `ESP_STATE_RUN;
				end
			end
			default: begin
				state_d = `ESP_STATE_TRIP;
			end
		endcase
	end

	wire run_d = (state_d == `ESP_STATE_RUN);

	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q <= `ESP_STATE_TRIP;
			reset_prev_q <= 1'b0;
			O_MOTOR_PWR_EN <= 1'b0;
			O_ESTOP_LOGIC <= 1'b0;
			O_RELAY_CLOSED <= 1'b0;
			O_BRAKE1 <= 1'b0;
			O_BRAKE2 <= 1'b0;
		end else begin
			state_q <= state_d;
			reset_prev_q <= clean_in[`ESP_IN_RESET];
			O_MOTOR_PWR_EN <= run_d;
			O_ESTOP_LOGIC <= sw_logic_out && run_d;
			O_RELAY_CLOSED <= sw_relay_out && run_d;
			O_BRAKE1 <= sw_brake_pol ? clean_in[`ESP_IN_BRAKE1] : !clean_in[`ESP_IN_BRAKE1];
			O_BRAKE2 <= sw_brake_pol ? clean_in[`ESP_IN_BRAKE2] : !clean_in[`ESP_IN_BRAKE2];
		end
	end

	// Blink divider and four-step pattern phase
	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			blink_cnt_q <= 32'h00000000;
			blink_tick_q <= 1'b0;
			phase_q <= 2'h0;
		end else begin
			blink_tick_q <= 1'b0;
			if (blink_cnt_q >= blink_div_q - 32'h00000001) begin
				blink_cnt_q <= 32'h00000000;
				blink_tick_q <= 1'b1;
			end else begin
				blink_cnt_q <= blink_cnt_q + 32'h00000001;
			end
			if (blink_tick_q) begin
				phase_q <= phase_q + 2'h1;
			end
		end
	end

	// LED code, most severe first
	always @* begin
		led_g_d = 1'b1;
		led_r_d = 1'b0;
		if (!loops_ok) begin
			led_g_d = phase_q[0];
			led_r_d = !phase_q[0];
		end else if (motor_uv) begin
			led_g_d = 1'b0;
			led_r_d = 1'b1;
		end else if (low24_uv) begin
			led_g_d = !phase_q[1];
			led_r_d = phase_q[1];
		end else if (regen_lock) begin
			led_g_d = (phase_q == 2'h0);
			led_r_d = (phase_q != 2'h0);
		end else if (state_q == `ESP_STATE_WAIT) begin
			led_g_d = phase_q[0];
			led_r_d = 1'b0;
		end
	end

	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_LED_GREEN <= 1'b0;
			O_LED_RED <= 1'b0;
		end else begin
			O_LED_GREEN <= led_g_d;
			O_LED_RED <= led_r_d;
		end
	end

	// APB decode
	wire apb_setup = I_PSEL && !I_PENABLE;
	wire apb_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;

	always @* begin
		rd_d = 32'h00000000;
		addr_ok = 1'b1;
		case (I_PADDR)
			`ESP_OFF_CTRL: begin
				rd_d[`ESP_CTRL_SOFT_ESTOP] = ctrl_q[`ESP_CTRL_SOFT_ESTOP];
			end
			`ESP_OFF_STATUS: begin
				rd_d[`ESP_ST_STATE_HI:`ESP_ST_STATE_LO] = state_q;
				rd_d[`ESP_ST_POWER] = O_MOTOR_PWR_EN;
				rd_d[`ESP_ST_RELAY] = O_RELAY_CLOSED;
				rd_d[`ESP_ST_LOGIC] = O_ESTOP_LOGIC;
				rd_d[`ESP_ST_BRAKE1] = O_BRAKE1;
				rd_d[`ESP_ST_BRAKE2] = O_BRAKE2;
				rd_d[`ESP_ST_SW_HI:`ESP_ST_SW_LO] = clean_in[7:0];
				rd_d[`ESP_ST_IN_HI:`ESP_ST_IN_LO] = clean_in[15:8];
			end
			`ESP_OFF_INT_STAT: begin
				rd_d[`ESP_INT_W-1:0] = int_stat_q;
			end
			`ESP_OFF_INT_MASK: begin
				rd_d[`ESP_INT_W-1:0] = int_mask_q;
			end
			`ESP_OFF_BLINK_DIV: begin
				rd_d = blink_div_q;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// Events for the interrupt status
	wire ev_trip = (state_q != `ESP_STATE_TRIP) && (state_d == `ESP_STATE_TRIP);
	wire ev_run = (state_q != `ESP_STATE_RUN) && run_d;
	wire [2:0] uv_now = {regen_lock, low24_uv, motor_uv};
	wire [2:0] uv_rise = uv_now & ~uv_prev_q;
	wire [`ESP_INT_W-1:0] ev_set = {uv_rise, ev_run, ev_trip};
	wire stat_wr = apb_wr && (I_PADDR == `ESP_OFF_INT_STAT);
	wire [`ESP_INT_W-1:0] stat_clr = stat_wr ? I_PWDATA[`ESP_INT_W-1:0] : {`ESP_INT_W{1'b0}};
	wire [`ESP_INT_W-1:0] stat_next = (int_stat_q & ~stat_clr) | ev_set;

	always @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PRDATA <= 32'h00000000;
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
			ctrl_q <= `ESP_CTRL_RESET;
			soft_reset_q <= 1'b0;
			int_stat_q <= {`ESP_INT_W{1'b0}};
			int_mask_q <= `ESP_INT_MASK_RESET;
			blink_div_q <= BLINK_RESET;
			uv_prev_q <= 3'h0;
			O_IRQ <= 1'b0;
		end else begin
			O_PREADY <= apb_setup;
			O_PSLVERR <= apb_setup && !addr_ok;
			if (apb_setup) begin
				O_PRDATA <= rd_d;
			end
			soft_reset_q <= 1'b0;
			if (apb_wr && addr_ok) begin
				case (I_PADDR)
					`ESP_OFF_CTRL: begin
						ctrl_q[`ESP_CTRL_SOFT_ESTOP] <= I_PWDATA[`ESP_CTRL_SOFT_ESTOP];
						soft_reset_q <= I_PWDATA[`ESP_CTRL_SOFT_RESET];
					end
					`ESP_OFF_INT_MASK: begin
						int_mask_q <= I_PWDATA[`ESP_INT_W-1:0];
					end
					`ESP_OFF_BLINK_DIV: begin
						blink_div_q <= (I_PWDATA == 32'h00000000) ? 32'h00000001 : I_PWDATA;
					end
					default: begin
						soft_reset_q <= 1'b0;
					end
				endcase
			end
			// Set wins over a same-cycle write-one clear
			uv_prev_q <= uv_now;
			int_stat_q <= stat_next;
			O_IRQ <= |(stat_next & int_mask_q);
		end
	end
endmodule

`default_nettype wire

// >>> verif/esp_contacts.sv
// Contact model: internal ESTOP loop and momentary reset contact.
// Assumes bench commands change just after the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module esp_contacts (
	// Clock
	input wire logic i_clk,
	// Bench commands
	input wire logic i_int,
	input wire logic i_press,
	// Contacts, high when closed
	output logic o_int = 1'h0,
	output logic o_reset
);
	logic [3:0] hold_q = 4'h0;
	always @(posedge i_clk) begin
		o_int <= i_int;
		if (i_press)
			hold_q <= 4'hC;
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
	end
	assign o_reset = hold_q != 4'h0;
endmodule
`default_nettype wire

// >>> verif/esp_supervisor_asserts.sv
// Port-level checks of the supervisor outputs.
// Assumes contacts settle within 2 sync plus 4 debounce cycles.
`timescale 1ns/1ps
`default_nettype none
module esp_sup_asserts (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic [7:0] I_CFG_SW,
	input wire logic I_ESTOP_INT_CLOSED,
	input wire logic I_ESTOP_EXT_CLOSED,
	input wire logic I_BRAKE1_REQ,
	input wire logic I_MOTOR_UV,
	input wire logic I_REGEN_LOCK,
	input wire logic O_MOTOR_PWR_EN,
	input wire logic O_ESTOP_LOGIC,
	input wire logic O_RELAY_CLOSED,
	input wire logic O_BRAKE1,
	input wire logic O_LED_GREEN,
	input wire logic O_LED_RED
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	chk_brake_pol: assert property (
		$stable({I_CFG_SW[1], I_BRAKE1_REQ})[*8] |->
		##[0:3] (O_BRAKE1 == (I_CFG_SW[1] ~^ I_BRAKE1_REQ))) else $error("brake level");
	chk_logic_pwr: assert property (
		O_ESTOP_LOGIC |-> O_MOTOR_PWR_EN) else $error("logic out without power");
	chk_relay_pwr: assert property (
		O_RELAY_CLOSED |-> O_MOTOR_PWR_EN) else $error("relay closed in estop");
	chk_int_loop: assert property (
		(I_CFG_SW[4] && !I_ESTOP_INT_CLOSED)[*8] |-> ##[0:3] !O_MOTOR_PWR_EN)
		else $error("power with int loop open");
	chk_ext_loop: assert property (
		(I_CFG_SW[5] && !I_ESTOP_EXT_CLOSED)[*8] |-> ##[0:3] !O_MOTOR_PWR_EN)
		else $error("power with ext loop open");
	chk_uv_trip: assert property (
		(I_CFG_SW[6] && I_MOTOR_UV)[*8] |-> ##[0:3] !O_MOTOR_PWR_EN)
		else $error("power during undervoltage");
	chk_led_ok: assert property (
		(O_MOTOR_PWR_EN && !I_REGEN_LOCK)[*8] |-> ##[0:2] (O_LED_GREEN && !O_LED_RED))
		else $error("led not solid green");
	chk_led_uv: assert property (
		(I_CFG_SW[6] && I_MOTOR_UV && I_CFG_SW[5:4] == 2'h0)[*8] |->
		##[0:3] (O_LED_RED && !O_LED_GREEN)) else $error("led not solid red");
endmodule
bind esp_supervisor esp_sup_asserts i_chk (
	.I_MCLK(I_MCLK),
	.I_RST_N(I_RST_N),
	.I_CFG_SW(I_CFG_SW),
	.I_ESTOP_INT_CLOSED(I_ESTOP_INT_CLOSED),
	.I_ESTOP_EXT_CLOSED(I_ESTOP_EXT_CLOSED),
	.I_BRAKE1_REQ(I_BRAKE1_REQ),
	.I_MOTOR_UV(I_MOTOR_UV),
	.I_REGEN_LOCK(I_REGEN_LOCK),
	.O_MOTOR_PWR_EN(O_MOTOR_PWR_EN),
	.O_ESTOP_LOGIC(O_ESTOP_LOGIC),
	.O_RELAY_CLOSED(O_RELAY_CLOSED),
	.O_BRAKE1(O_BRAKE1),
	.O_LED_GREEN(O_LED_GREEN),
	.O_LED_RED(O_LED_RED)
);
`default_nettype wire

// >>> verif/tb_estop_motor_power_supervisor.sv
// Self-checking bench for the supervisor.
// Assumes the design and the contact model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_estop_motor_power_supervisor;
	logic mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h0, cfg = 8'h3F;
	logic [31:0] pwdata = 32'h0, rdat;
	logic int_r = 1'h0, ext_c = 1'h0, press = 1'h0, b1 = 1'h0, b2 = 1'h0;
	logic muv = 1'h0, l24 = 1'h0, regen = 1'h0, rerr;
	wire logic int_c, rst_c, pready, pslverr, pwr, lg, rly, bk1, bk2, gr, rd, irq;
	wire logic [31:0] prdata;
	int bad_count = 0, tests_run = 0;
	always #2.5 mclk = ~mclk;
	esp_contacts i_con (.i_clk(mclk), .i_int(int_r), .i_press(press), .o_int(int_c),
		.o_reset(rst_c));
	esp_supervisor #(.DEBOUNCE_CYCLES(18'h4), .BLINK_RESET(32'h8)) i_dut (
		.I_MCLK(mclk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_CFG_SW(cfg),
		.I_ESTOP_INT_CLOSED(int_c), .I_ESTOP_EXT_CLOSED(ext_c), .I_RESET_CONTACT(rst_c),
		.I_BRAKE1_REQ(b1), .I_BRAKE2_REQ(b2), .I_MOTOR_UV(muv), .I_LOW24_UV(l24),
		.I_REGEN_LOCK(regen), .O_MOTOR_PWR_EN(pwr), .O_ESTOP_LOGIC(lg),
		.O_RELAY_CLOSED(rly), .O_BRAKE1(bk1), .O_BRAKE2(bk2), .O_LED_GREEN(gr),
		.O_LED_RED(rd), .O_IRQ(irq));
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		cyc(1);
		penable <= 1'h1;
		do begin
			cyc(1);
			n++;
		end while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		cyc(1);
		chk(n, 1);
	endtask
	// Counts lit cycles over two full four-step LED patterns (64 clocks)
	task automatic led(input int eg, er);
		int g, r;
		g = 0;
		r = 0;
		repeat (64) begin
			cyc(1);
			g += (gr === 1'h1);
			r += (rd === 1'h1);
		end
		chk(g, eg);
		chk(r, er);
	endtask
	task t_reg;
		// No power before the switch bank has been read
		repeat (12) begin
			cyc(1);
			chk(pwr, 1'h0);
		end
		apb(1'h0, 8'h10, 32'h0);
		chk(rdat, 32'h8);
		apb(1'h1, 8'h10, 32'h0);
		apb(1'h0, 8'h10, 32'h0);
		chk(rdat, 32'h1);
		apb(1'h1, 8'h10, 32'h8);
		apb(1'h0, 8'h14, 32'h0);
		chk(rdat, 32'h0);
		chk(rerr, 1'h1);
		$display("t_reg done");
	endtask
	task t_brk;
		for (int i = 0; i < 4; i++) begin
			cfg[1] <= i[1];
			b1 <= i[0];
			b2 <= !i[0];
			cyc(12);
			chk({bk1, bk2}, {i[1] ~^ i[0], i[1] ~^ !i[0]});
		end
		$display("t_brk done");
	endtask
	task t_seq;
		int_r <= 1'h1;
		ext_c <= 1'h1;
		cyc(16);
		apb(1'h0, 8'h04, 32'h0);
		chk(rdat[2:0], 3'h1);
		led(32, 0);
		apb(1'h1, 8'h08, 32'h1F);
		apb(1'h1, 8'h0C, 32'h2);
		chk(irq, 1'h0);
		press <= 1'h1;
		cyc(1);
		press <= 1'h0;
		cyc(24);
		chk({pwr, lg, rly, irq}, 4'hF);
		apb(1'h1, 8'h08, 32'h2);
		cyc(1);
		chk(irq, 1'h0);
		int_r <= 1'h0;
		cyc(12);
		chk({pwr, lg, rly}, 3'h0);
		led(32, 32);
		int_r <= 1'h1;
		cyc(16);
		chk(pwr, 1'h0);
		// Software reset pulse and software stop
		apb(1'h1, 8'h00, 32'h2);
		cyc(2);
		chk({pwr, irq}, 2'h3);
		apb(1'h1, 8'h00, 32'h1);
		cyc(2);
		chk(pwr, 1'h0);
		apb(1'h0, 8'h00, 32'h0);
		chk(rdat, 32'h1);
		apb(1'h1, 8'h00, 32'h0);
		cyc(12);
		chk(pwr, 1'h0);
		$display("t_seq done");
	endtask
	task t_ign;
		cfg <= 8'h02;
		int_r <= 1'h0;
		ext_c <= 1'h0;
		cyc(16);
		chk({pwr, lg, rly}, 3'h4);
		led(64, 0);
		muv <= 1'h1;
		cyc(12);
		chk(pwr, 1'h1);
		cfg <= 8'h42;
		cyc(12);
		chk(pwr, 1'h0);
		led(0, 64);
		muv <= 1'h0;
		l24 <= 1'h1;
		cyc(12);
		led(32, 32);
		l24 <= 1'h0;
		regen <= 1'h1;
		cyc(12);
		led(16, 48);
		regen <= 1'h0;
		cfg <= 8'h22;
		cyc(12);
		chk(pwr, 1'h0);
		ext_c <= 1'h1;
		cyc(16);
		chk(pwr, 1'h1);
		$display("t_ign done");
	endtask
	task results;
		$display("Tests %0d bad %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		cyc(10);
		rst_n <= 1'h1;
		cyc(1);
		t_reg;
		t_brk;
		t_seq;
		t_ign;
		results;
	end
	initial begin
		#100000;
		bad_count++;
		results;
	end
endmodule
`default_nettype wire
